/* logic/tfl_loop_ctrl.sv */
// Test loop controller: APB registers, loop command handling, frame loop.
// Assumes decoder frames arrive as one-cycle strobes at least two cycles
// apart, and that software carries the layer 3 commands to the CMD register.
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/100ps

module tfl_loop_ctrl import tfl_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic dl_valid,
  input wire logic [FRAME_W-1:0] dl_bits,
  input wire logic [8:0] dl_len,
  input wire tfl_rx_type dl_rx_type,
  input wire logic dl_bfi,
  input wire logic [1:0] dl_codec_mode,
  input wire logic dl_facch,
  output logic ul_valid,
  output logic [FRAME_W-1:0] ul_bits,
  output logic [8:0] ul_len,
  output logic [1:0] ul_codec_mode,
  output logic ul_speech_good,
  input wire logic dl_burst_valid,
  input wire logic dl_burst_traffic,
  input wire logic [BURST_W-1:0] dl_burst_bits,
  output logic ul_burst_valid,
  output logic [BURST_W-1:0] ul_burst_bits,
  output logic loop_a_closed,
  output logic loop_c_closed,
  output logic dai_active,
  output logic close_ack,
  output logic ratscch_enable,
  output logic cmr_enable,
  output logic codec_cmd_ignore
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic test_en;
    logic tch_act;
    tfl_chan_type chan;
    logic [1:0] acs_m1;
    logic dai_req;
    logic closed;
    logic loop_c;
    logic dai_act;
    logic [7:0] discards;
    logic [7:0] acks;
    logic close_ack;
    logic ratscch_en;
    logic cmr_en;
    logic cmd_ign;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic ul_valid;
    logic [FRAME_W-1:0] ul_bits;
    logic [8:0] ul_len;
    logic [1:0] ul_mode;
    logic ul_good;
    logic pend;
    logic [FRAME_W-1:0] pend_bits;
    logic loop_a_q;
    logic loop_c_q;
  } tfl_state_type;

  tfl_state_type st;
  tfl_state_type next_st;

  logic access;
  logic adaptive;
  logic half_ad;
  logic loop_a;
  logic close_ok;
  logic [8:0] frame_len;
  tfl_shape_type shape;
  logic [FRAME_W-1:0] shaped;

  // ==========================================================================
  // frame classification
  assign access = psel & penable & ~st.pready;
  assign adaptive = (st.chan == CH_AFULL) | (st.chan == CH_AHALF);
  assign half_ad = (st.chan == CH_AHALF);
  assign loop_a = st.closed & ~st.loop_c;
  assign close_ok = st.tch_act & ~st.closed & ~st.dai_act;

  always_comb begin
    unique case (st.chan)
      CH_FULL: frame_len = LEN_FULL;
      CH_ENH: frame_len = LEN_ENH;
      CH_HALF: frame_len = LEN_HALF;
      default: frame_len = dl_len;
    endcase
  end

  always_comb begin
    shape = SHAPE_ZERO;
    if (!adaptive) begin
      shape = dl_rx_type == RX_SPEECH_BAD ? SHAPE_ZERO : SHAPE_FULL;
    end else begin
      unique case (dl_rx_type)
        RX_SPEECH_GOOD: shape = SHAPE_FULL;
        RX_SID_UPDATE: shape = dl_bfi ? SHAPE_ZERO : SHAPE_SIDE;
        RX_RATSCCH: shape = dl_bfi ? SHAPE_ZERO : SHAPE_SIDE;
        default: shape = SHAPE_ZERO;
      endcase
    end
  end

  tfl_frame_shaper #(
    .W(FRAME_W)
  ) u_shaper (
    .bits_in(dl_bits),
    .len(frame_len),
    .shape(shape),
    .bits_out(shaped)
  );

  tfl_burst_loop u_burst (
    .pclk(pclk),
    .presetn(presetn),
    .enable(st.closed & st.loop_c),
    .dl_burst_valid(dl_burst_valid),
    .dl_burst_traffic(dl_burst_traffic),
    .dl_burst_bits(dl_burst_bits),
    .ul_burst_valid(ul_burst_valid),
    .ul_burst_bits(ul_burst_bits)
  );

  // ==========================================================================
  // next state
  always_comb begin
    next_st = st;
    next_st.close_ack = 1'b0;
    next_st.ul_valid = 1'b0;
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;
    if (access) begin
      next_st.pready = 1'b1;
      next_st.prdata = '0;
      unique case (paddr)
        OFS_CTRL: begin
          if (pwrite) begin
            next_st.test_en = pwdata[CTRL_TEST_EN];
            next_st.tch_act = pwdata[CTRL_TCH_ACT];
            next_st.chan = tfl_chan_type'(pwdata[CTRL_CHAN_LO +: 3]);
            next_st.acs_m1 = pwdata[CTRL_ACS_LO +: 2];
            next_st.dai_req = pwdata[CTRL_DAI_REQ];
          end else begin
            next_st.prdata[CTRL_TEST_EN] = st.test_en;
            next_st.prdata[CTRL_TCH_ACT] = st.tch_act;
            next_st.prdata[CTRL_CHAN_LO +: 3] = st.chan;
            next_st.prdata[CTRL_ACS_LO +: 2] = st.acs_m1;
            next_st.prdata[CTRL_DAI_REQ] = st.dai_req;
          end
        end
        OFS_CMD: begin
          // layer 2 delivery is done before software writes here
          if (pwrite && pwdata[CMD_CLOSE]) begin
            if (close_ok && st.test_en) begin
              next_st.closed = 1'b1;
              next_st.loop_c = pwdata[CMD_LOOP_C];
              next_st.close_ack = 1'b1;
              next_st.acks = st.acks + 8'h01;
            end else begin
              next_st.discards = st.discards + 8'h01;
            end
          end else if (pwrite && pwdata[CMD_OPEN]) begin
            next_st.closed = 1'b0;
          end
        end
        OFS_STATUS: begin
          if (!pwrite) begin
            next_st.prdata[STAT_CLOSED] = st.closed;
            next_st.prdata[STAT_LOOP_C] = st.loop_c;
            next_st.prdata[STAT_DAI] = st.dai_act;
            next_st.prdata[STAT_DISC_LO +: 8] = st.discards;
            next_st.prdata[STAT_ACK_LO +: 8] = st.acks;
          end
        end
        default: next_st.pslverr = 1'b1;
      endcase
    end

    // loop never survives loss of test mode or of the traffic channel
    if (!next_st.test_en || !next_st.tch_act) begin
      next_st.closed = 1'b0;
    end
    // audio test only starts while no loop is closed
    next_st.dai_act = next_st.dai_req & next_st.test_en
                      & (st.dai_act | ~next_st.closed);
    if (next_st.dai_act) begin
      next_st.closed = 1'b0;
    end

    next_st.ratscch_en = ~st.closed;
    next_st.cmr_en = ~(st.closed & adaptive);
    next_st.cmd_ign = st.closed & adaptive & (st.acs_m1 != 2'b00);

    if (st.pend) begin
      // second half of a half-rate pair
      next_st.ul_valid = 1'b1;
      next_st.ul_bits = st.pend_bits;
      next_st.pend = 1'b0;
    end else if (loop_a && dl_valid && !(dl_facch && !adaptive)) begin
      next_st.ul_valid = 1'b1;
      next_st.ul_len = frame_len;
      next_st.ul_good = 1'b1;
      next_st.ul_bits = shaped;
      if (adaptive) begin
        unique case (dl_rx_type)
          RX_NO_DATA, RX_RATSCCH, RX_SID_UPDATE, RX_SID_UPDATE_INH,
          RX_SID_FIRST, RX_SID_FIRST_P2, RX_SID_FIRST_INH,
          RX_SID_BAD: next_st.ul_mode = st.ul_mode;
          default: next_st.ul_mode = dl_codec_mode;
        endcase
      end else begin
        next_st.ul_mode = dl_codec_mode;
      end
      // adaptive half rate: a control or silence update frame spans two uplink frames
      if (half_ad && (dl_rx_type == RX_SID_UPDATE
                      || dl_rx_type == RX_SID_BAD
                      || dl_rx_type == RX_RATSCCH)) begin
        next_st.ul_bits = '0;
        next_st.pend = 1'b1;
        next_st.pend_bits = shaped;
      end
    end
    if (!next_st.closed) begin
      next_st.pend = 1'b0;
    end
    // loop flags registered so the status pins come from flops
    next_st.loop_a_q = next_st.closed & ~next_st.loop_c;
    next_st.loop_c_q = next_st.closed & next_st.loop_c;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // outputs
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign ul_valid = st.ul_valid;
  assign ul_bits = st.ul_bits;
  assign ul_len = st.ul_len;
  assign ul_codec_mode = st.ul_mode;
  assign ul_speech_good = st.ul_good;
  assign loop_a_closed = st.loop_a_q;
  assign loop_c_closed = st.loop_c_q;
  assign dai_active = st.dai_act;
  assign close_ack = st.close_ack;
  assign ratscch_enable = st.ratscch_en;
  assign cmr_enable = st.cmr_en;
  assign codec_cmd_ignore = st.cmd_ign;

  // ==========================================================================
  // assertions
  logic cmd_close_wr;
  assign cmd_close_wr = access & pwrite & (paddr == OFS_CMD)
                        & pwdata[CMD_CLOSE];

  property p_excl;
    @(posedge pclk) disable iff (!presetn)
      !(st.closed && st.dai_act);
  endproperty
  a_excl: assert property (p_excl)
    else $error("loop and audio test active together");

  property p_discard;
    @(posedge pclk) disable iff (!presetn)
      cmd_close_wr && (!st.tch_act || st.closed)
      |=> st.discards == $past(st.discards) + 8'h01 && !close_ack;
  endproperty
  a_discard: assert property (p_discard)
    else $error("close command not discarded");

  property p_ack;
    @(posedge pclk) disable iff (!presetn)
      cmd_close_wr && close_ok && st.test_en && !st.dai_req
      |=> close_ack && st.closed ##1 !close_ack;
  endproperty
  a_ack: assert property (p_ack)
    else $error("accepted close not acknowledged");

  property p_bad;
    @(posedge pclk) disable iff (!presetn)
      loop_a && !st.pend && dl_valid && dl_rx_type == RX_SPEECH_BAD
      && !dl_facch
      && st.test_en && st.tch_act && !access && !st.dai_req
      |=> ul_valid && ul_bits == '0;
  endproperty
  a_bad: assert property (p_bad)
    else $error("bad frame not zeroed");

  property p_good;
    @(posedge pclk) disable iff (!presetn)
      ul_valid |-> ul_speech_good;
  endproperty
  a_good: assert property (p_good)
    else $error("uplink frame not marked good");

  property p_ratscch;
    @(posedge pclk) disable iff (!presetn)
      st.closed [*2] |-> !ratscch_enable;
  endproperty
  a_ratscch: assert property (p_ratscch)
    else $error("rate control protocol still on");

  property p_side;
    @(posedge pclk) disable iff (!presetn)
      ul_valid |-> ul_bits[FRAME_W-1:int'(LEN_SIDE)] == '0
      || $past(dl_rx_type) == RX_SPEECH_GOOD || !$past(adaptive);
  endproperty
  a_side: assert property (p_side)
    else $error("side frame carries bits beyond its field");

  property p_erase_half;
    @(posedge pclk) disable iff (!presetn)
      loop_a && !st.pend && dl_valid && half_ad && dl_rx_type == RX_SID_BAD
      && st.test_en && st.tch_act && !access && !st.dai_req
      |=> ul_valid && ul_bits == '0 ##1 ul_valid && ul_bits == '0;
  endproperty
  a_erase_half: assert property (p_erase_half)
    else $error("erased half-rate update not two zero frames");

  property p_open;
    @(posedge pclk) disable iff (!presetn)
      !st.test_en |-> !st.closed ##1 !ul_burst_valid;
  endproperty
  a_open: assert property (p_open)
    else $error("loop closed without test enable");

  property p_facch;
    @(posedge pclk) disable iff (!presetn)
      loop_a && !st.pend && dl_valid && dl_facch && !adaptive
      |=> !ul_valid;
  endproperty
  a_facch: assert property (p_facch)
    else $error("stolen frame looped on fixed-rate channel");

endmodule // tfl_loop_ctrl

/* logic/tfl_pkg.sv */
// Constants, encodings and register map of the traffic-channel test loop.
// Assumes a single pclk domain and an APB master for register access.
//
// Summary of operation
// - loop commands come as layer 3 messages, SAPI 0, acknowledged mode
// - a traffic loop and the audio interface test never run together
// - close command discarded without traffic channel or with a loop closed
// - accepted close command closes the loop and returns an acknowledgment
// - burst loop returns 114 traffic bits, own midamble, no SACCH or idle
// - frame loop feeds each good decoded frame back to the encoder
// - frame length 260, 244, 112 bits, or decoded length when adaptive
// - bad speech frame becomes an all-zero uplink frame
// - stolen frame on fixed-rate channels gets no looped frame
// - with several codec modes, downlink mode commands are ignored
// - no codec mode requests; uplink indication follows looped frame
// - silence, no-data and control frames reuse the previous uplink mode
// - adaptive uplink frames always go out as good speech
// - valid silence update parameters fill first 35 bits, rest zero
// - half-rate silence update: zero frame then parameter frame
// - erased silence update: zero frame, two of them on half rate
// - with loop closed the rate control protocol is switched off
// - valid rate control frame data fills first 35 bits, rest zero
// - half-rate rate control pair: zero frame then data frame
// - erased rate control frame: zero frame, two on half rate
// - onset, first silence and plain no-data give a zero frame
// - half-rate second silence part and inhibit frames give zero frame

package tfl_pkg;

  localparam int FRAME_W = 260;
  localparam int BURST_W = 114;
  localparam logic [8:0] LEN_FULL = 9'h104;
  localparam logic [8:0] LEN_ENH = 9'h0F4;
  localparam logic [8:0] LEN_HALF = 9'h070;
  localparam logic [8:0] LEN_SIDE = 9'h023;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;

  // control register fields
  localparam int CTRL_TEST_EN = 0;
  localparam int CTRL_TCH_ACT = 1;
  localparam int CTRL_CHAN_LO = 2;
  localparam int CTRL_ACS_LO = 5;
  localparam int CTRL_DAI_REQ = 7;

  // command register fields
  localparam int CMD_CLOSE = 0;
  localparam int CMD_OPEN = 1;
  localparam int CMD_LOOP_C = 2;

  // status register fields
  localparam int STAT_CLOSED = 0;
  localparam int STAT_LOOP_C = 1;
  localparam int STAT_DAI = 2;
  localparam int STAT_DISC_LO = 8;
  localparam int STAT_ACK_LO = 16;

  typedef enum logic [2:0] {
    CH_FULL = 3'b000,
    CH_ENH = 3'b001,
    CH_HALF = 3'b010,
    CH_AFULL = 3'b011,
    CH_AHALF = 3'b100
  } tfl_chan_type;

  typedef enum logic [3:0] {
    RX_SPEECH_GOOD = 4'b0000,
    RX_SPEECH_BAD = 4'b0001,
    RX_ONSET = 4'b0010,
    RX_SID_FIRST = 4'b0011,
    RX_SID_FIRST_P2 = 4'b0100,
    RX_SID_FIRST_INH = 4'b0101,
    RX_SID_UPDATE = 4'b0110,
    RX_SID_UPDATE_INH = 4'b0111,
    RX_SID_BAD = 4'b1000,
    RX_NO_DATA = 4'b1001,
    RX_RATSCCH = 4'b1010
  } tfl_rx_type;

  typedef enum logic [1:0] {
    SHAPE_ZERO = 2'b00,
    SHAPE_FULL = 2'b01,
    SHAPE_SIDE = 2'b10
  } tfl_shape_type;

endpackage

/* logic/tfl_frame_shaper.sv */
// Masks a decoded frame to its looped length, to the first side bits,
// or to all zeros. Purely combinational; the caller registers the result.
`timescale 1ns/100ps

module tfl_frame_shaper import tfl_pkg::*; #(
  parameter int W = FRAME_W
) (
  input wire logic [W-1:0] bits_in,
  input wire logic [8:0] len,
  input wire tfl_shape_type shape,
  output logic [W-1:0] bits_out
);

  always_comb begin
    for (int i = 0; i < W; i++) begin
      unique case (shape)
        SHAPE_FULL: bits_out[i] = bits_in[i] & (i < int'(len));
        SHAPE_SIDE: bits_out[i] = bits_in[i] & (i < int'(LEN_SIDE));
        default: bits_out[i] = 1'b0;
      endcase
    end
  end

endmodule // tfl_frame_shaper

/* logic/tfl_burst_loop.sv */
// Burst-by-burst loop: returns decrypted, undecoded traffic burst bits.
// Assumes the caller marks SACCH and idle bursts as non-traffic.
`timescale 1ns/100ps

module tfl_burst_loop import tfl_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic dl_burst_valid,
  input wire logic dl_burst_traffic,
  input wire logic [BURST_W-1:0] dl_burst_bits,
  output logic ul_burst_valid,
  output logic [BURST_W-1:0] ul_burst_bits
);

  typedef struct packed {
    logic valid;
    logic [BURST_W-1:0] bits;
  } tfl_burst_state_type;

  tfl_burst_state_type st;
  tfl_burst_state_type next_st;

  // midamble is not looked at; uplink keeps its own training sequence
  always_comb begin
    next_st = st;
    next_st.valid = enable & dl_burst_valid & dl_burst_traffic;
    if (next_st.valid) begin
      next_st.bits = dl_burst_bits;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign ul_burst_valid = st.valid;
  assign ul_burst_bits = st.bits;

endmodule // tfl_burst_loop

/* tb/tfl_sim_model.sv */
// Stand-in for the test equipment on the burst path: sends traffic and
// non-traffic bursts and checks what comes back.
// Assumes the burst loop is closed whenever run is high.
`timescale 1ns/100ps

module tfl_sim_model import tfl_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic ul_burst_valid,
  input wire logic [BURST_W-1:0] ul_burst_bits,
  output logic dl_burst_valid,
  output logic dl_burst_traffic,
  output logic [BURST_W-1:0] dl_burst_bits,
  output int errors,
  output int looped
);
  // ==========================================================
  // burst source and return check
  logic [3:0] cnt;
  logic sent_q;
  logic [BURST_W-1:0] exp_q;
  logic [127:0] pat;

  assign pat = {4{cnt, 28'h5A3C96E}};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 4'h0;
      dl_burst_valid <= 1'b0;
      dl_burst_traffic <= 1'b0;
      dl_burst_bits <= '0;
      sent_q <= 1'b0;
      exp_q <= '0;
      errors <= 0;
      looped <= 0;
    end else begin
      cnt <= cnt + 4'h1;
      dl_burst_valid <= run && cnt[1:0] == 2'h0;
      // every fourth burst stands for a control or idle slot
      dl_burst_traffic <= cnt[3:2] != 2'h3;
      // between bursts the bits alternate between the last burst and its inverse
      dl_burst_bits <= (run && cnt[1:0] == 2'h0) ? pat[BURST_W-1:0]
                                                : ~dl_burst_bits;
      sent_q <= dl_burst_valid && dl_burst_traffic;
      exp_q <= dl_burst_bits;
      if (sent_q) begin
        looped <= looped + 1;
        if (ul_burst_valid !== 1'b1 || ul_burst_bits !== exp_q) begin
          errors <= errors + 1;
        end
      end else if (ul_burst_valid === 1'b1) begin
        errors <= errors + 1;
      end
    end
  end
endmodule // tfl_sim_model

/* tb/tb_top.sv */
// Self-checking bench for the test loop controller: register and discarded
// close checks, frame table, then command, exclusion, burst loop and reset cases.
// Assumes the burst far side is tfl_sim_model; registers over APB.
`timescale 1ns/100ps

module tb_top import tfl_pkg::*;;
  typedef struct {
    tfl_chan_type ch;
    tfl_rx_type rx;
    logic bfi, fa;
    logic [1:0] md;
    logic [8:0] len;
    int kind, n;
    logic [1:0] xmd;
  } tfl_row_type;
  localparam int NROWS = 21;
  // kind: 0 nothing, 1 whole frame, 2 side field, 3 zeros
  tfl_row_type rows [NROWS] = '{
    '{CH_FULL, RX_SPEECH_GOOD, 1'h0, 1'h0, 2'h0, LEN_FULL, 1, 1, 2'h0},
    '{CH_FULL, RX_SPEECH_BAD, 1'h1, 1'h0, 2'h0, LEN_FULL, 3, 1, 2'h0},
    '{CH_FULL, RX_SPEECH_GOOD, 1'h0, 1'h1, 2'h0, LEN_FULL, 0, 0, 2'h0},
    '{CH_ENH, RX_SPEECH_GOOD, 1'h0, 1'h0, 2'h0, LEN_ENH, 1, 1, 2'h0},
    '{CH_HALF, RX_SPEECH_GOOD, 1'h0, 1'h0, 2'h0, LEN_HALF, 1, 1, 2'h0},
    '{CH_AFULL, RX_SPEECH_GOOD, 1'h0, 1'h0, 2'h2, 9'h05F, 1, 1, 2'h2},
    '{CH_AFULL, RX_SID_UPDATE, 1'h0, 1'h0, 2'h1, 9'h05F, 2, 1, 2'h2},
    '{CH_AFULL, RX_SPEECH_GOOD, 1'h0, 1'h0, 2'h3, 9'h09F, 1, 1, 2'h3},
    '{CH_AFULL, RX_RATSCCH, 1'h0, 1'h0, 2'h0, 9'h09F, 2, 1, 2'h3},
    '{CH_AFULL, RX_SID_BAD, 1'h1, 1'h0, 2'h1, 9'h09F, 3, 1, 2'h3},
    '{CH_AFULL, RX_RATSCCH, 1'h1, 1'h0, 2'h1, 9'h09F, 3, 1, 2'h3},
    '{CH_AFULL, RX_ONSET, 1'h0, 1'h0, 2'h3, 9'h09F, 3, 1, 2'h3},
    '{CH_AFULL, RX_NO_DATA, 1'h0, 1'h0, 2'h0, 9'h09F, 3, 1, 2'h3},
    '{CH_AFULL, RX_SID_FIRST, 1'h0, 1'h0, 2'h0, 9'h09F, 3, 1, 2'h3},
    '{CH_AHALF, RX_SPEECH_GOOD, 1'h0, 1'h0, 2'h1, 9'h054, 1, 1, 2'h1},
    '{CH_AHALF, RX_SID_UPDATE, 1'h0, 1'h0, 2'h2, 9'h054, 2, 2, 2'h1},
    '{CH_AHALF, RX_RATSCCH, 1'h0, 1'h0, 2'h2, 9'h054, 2, 2, 2'h1},
    '{CH_AHALF, RX_SID_BAD, 1'h1, 1'h0, 2'h2, 9'h054, 3, 2, 2'h1},
    '{CH_AHALF, RX_RATSCCH, 1'h1, 1'h0, 2'h2, 9'h054, 3, 2, 2'h1},
    '{CH_AHALF, RX_SID_FIRST_P2, 1'h0, 1'h0, 2'h0, 9'h054, 3, 1, 2'h1},
    '{CH_AHALF, RX_SID_UPDATE_INH, 1'h0, 1'h0, 2'h0, 9'h054, 3, 1, 2'h1}
  };

  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic dl_valid, dl_bfi, dl_facch, ul_valid, ul_speech_good;
  logic [FRAME_W-1:0] dl_bits, ul_bits;
  logic [8:0] dl_len, ul_len;
  tfl_rx_type dl_rx_type;
  logic [1:0] dl_codec_mode, ul_codec_mode;
  logic dl_burst_valid, dl_burst_traffic, ul_burst_valid;
  logic [BURST_W-1:0] dl_burst_bits, ul_burst_bits;
  logic loop_a_closed, loop_c_closed, dai_active, close_ack;
  logic ratscch_enable, cmr_enable, codec_cmd_ignore, run, err, ack;
  int model_err, looped, failures, check_count, disc, acks;

  tfl_loop_ctrl i_tfl_loop_ctrl (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dl_valid(dl_valid),
    .dl_bits(dl_bits), .dl_len(dl_len), .dl_rx_type(dl_rx_type),
    .dl_bfi(dl_bfi), .dl_codec_mode(dl_codec_mode), .dl_facch(dl_facch),
    .ul_valid(ul_valid), .ul_bits(ul_bits), .ul_len(ul_len),
    .ul_codec_mode(ul_codec_mode), .ul_speech_good(ul_speech_good),
    .dl_burst_valid(dl_burst_valid), .dl_burst_traffic(dl_burst_traffic),
    .dl_burst_bits(dl_burst_bits), .ul_burst_valid(ul_burst_valid),
    .ul_burst_bits(ul_burst_bits), .loop_a_closed(loop_a_closed),
    .loop_c_closed(loop_c_closed), .dai_active(dai_active),
    .close_ack(close_ack), .ratscch_enable(ratscch_enable),
    .cmr_enable(cmr_enable), .codec_cmd_ignore(codec_cmd_ignore)
  );

  tfl_sim_model i_tfl_sim_model (
    .pclk(pclk), .presetn(presetn), .run(run),
    .ul_burst_valid(ul_burst_valid), .ul_burst_bits(ul_burst_bits),
    .dl_burst_valid(dl_burst_valid), .dl_burst_traffic(dl_burst_traffic),
    .dl_burst_bits(dl_burst_bits), .errors(model_err), .looped(looped)
  );

  always #12.5 pclk = ~pclk;

  // ==========================================================
  // shared tasks
  task automatic tally_and_finish();
    if (failures == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [FRAME_W-1:0] seen,
                       input logic [FRAME_W-1:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // one transfer; waits for pready, keeps the answer in rd, err, ack
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      #1;
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      failures++;
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    ack = close_ack;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  function automatic logic [31:0] ctl(input logic en, input tfl_chan_type ch,
                                      input logic dai);
    return {24'h000000, dai, 2'h3, ch, 1'b1, en};
  endfunction

  task automatic chk_st(input logic c, input logic lc, input logic dai);
    apb(1'b0, OFS_STATUS, 32'h0);
    check(rd, {8'h00, acks[7:0], disc[7:0], 5'h00, dai, lc, c}, "status");
  endtask

  task automatic set_loop(input tfl_chan_type ch, input logic lc);
    apb(1'b1, OFS_CMD, 32'h00000002);
    apb(1'b1, OFS_CTRL, ctl(1'b1, ch, 1'b0));
    apb(1'b1, OFS_CMD, {29'h0, lc, 2'h1});
    acks++;
    check(ack, 1'b1, "close_ack");
    check(lc ? loop_c_closed : loop_a_closed, 1'b1, "loop closed");
  endtask

  function automatic logic [FRAME_W-1:0] msk(input logic [FRAME_W-1:0] v,
                                             input int n);
    for (int b = n; b < FRAME_W; b++) v[b] = 1'b0;
    return v;
  endfunction

  task automatic send_row(input tfl_row_type r,
                          input logic [FRAME_W-1:0] pat);
    logic [FRAME_W-1:0] exp;
    int seen;
    exp = (r.kind == 1) ? msk(pat, r.len) :
          (r.kind == 2) ? msk(pat, LEN_SIDE) : '0;
    seen = 0;
    @(posedge pclk);
    dl_valid <= 1'b1;
    dl_bits <= pat;
    dl_len <= r.len;
    dl_rx_type <= r.rx;
    dl_bfi <= r.bfi;
    dl_codec_mode <= r.md;
    dl_facch <= r.fa;
    for (int i = 0; i < 6; i++) begin
      @(posedge pclk);
      dl_valid <= 1'b0;
      dl_bits <= ~pat;
      #1;
      if (ul_valid === 1'b1) begin
        seen++;
        check(ul_bits, (seen < r.n) ? '0 : exp, "ul_bits");
        if (r.kind == 1) check(ul_len, r.len, "ul_len");
        if (r.ch inside {CH_AFULL, CH_AHALF}) begin
          check(ul_codec_mode, r.xmd, "codec mode");
          check(ul_speech_good, 1'b1, "speech good");
        end
      end
    end
    check(FRAME_W'(seen), FRAME_W'(r.n), "frame count");
  endtask

  // ==========================================================
  // main sequence
  initial begin
    pclk = 0;
    presetn = 0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {dl_valid, dl_bits, dl_len, dl_bfi, dl_codec_mode, dl_facch} = '0;
    dl_rx_type = RX_SPEECH_GOOD;
    {run, failures, check_count, disc, acks} = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    chk_st(1'b0, 1'b0, 1'b0);
    check(ratscch_enable, 1'b1, "ratscch before close");
    apb(1'b0, OFS_CMD, 32'h0);
    check(rd, 32'h0, "cmd read");
    apb(1'b0, 8'h0C, 32'h0);
    check({err, rd}, {1'b1, 32'h0}, "unmapped");
    apb(1'b1, OFS_CTRL, 32'h00000001);
    apb(1'b1, OFS_CMD, 32'h00000001);
    disc++;
    check(ack, 1'b0, "close without channel");
    chk_st(1'b0, 1'b0, 1'b0);
    for (int i = 0; i < NROWS; i++) begin
      if (i == 0 || rows[i].ch != rows[i-1].ch) set_loop(rows[i].ch, 1'b0);
      send_row(rows[i], FRAME_W'({9{32'hC3A55A3C}}) ^ FRAME_W'(i));
    end
    check(ratscch_enable, 1'b0, "ratscch closed");
    check(cmr_enable, 1'b0, "mode requests");
    check(codec_cmd_ignore, 1'b1, "mode commands");
    apb(1'b1, OFS_CMD, 32'h00000001);
    disc++;
    check(ack, 1'b0, "second close");
    apb(1'b1, OFS_CTRL, ctl(1'b1, CH_AHALF, 1'b1));
    chk_st(1'b1, 1'b0, 1'b0);
    apb(1'b1, OFS_CTRL, ctl(1'b0, CH_AHALF, 1'b0));
    check(loop_a_closed, 1'b0, "enable dropped");
    apb(1'b1, OFS_CTRL, ctl(1'b1, CH_FULL, 1'b1));
    apb(1'b1, OFS_CMD, 32'h00000001);
    disc++;
    chk_st(1'b0, 1'b0, 1'b1);
    check(dai_active, 1'b1, "dai active");
    set_loop(CH_FULL, 1'b1);
    chk_st(1'b1, 1'b1, 1'b0);
    run <= 1'b1;
    repeat (60) @(posedge pclk);
    run <= 1'b0;
    repeat (4) @(posedge pclk);
    check(FRAME_W'(model_err), '0, "burst return");
    check(FRAME_W'(looped > 8), 1'b1, "bursts looped");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    {disc, acks} = '0;
    check(loop_c_closed, 1'b0, "reset opens loop");
    chk_st(1'b0, 1'b0, 1'b0);
    tally_and_finish();
  end
endmodule // tb_top
